// file: core/ext_irq_map.svh
// Notes on behaviour
// - Pending flag reads 1 while request pending
// - Writing 1 to ack strobe clears latch
// - Ack strobe reads 0, reset clears it
// - Select 1: edges and levels; 0: edges
// - Break permit 1 lets ack clear latch
// - Latch cleared in break stays cleared
// - Break permit 0 blocks ack in break
// - Low pin sets; fetch, ack, reset clear
// - Level mode: pending until ack and high
// - Mask set blocks request to CPU
// - Pending flag ignores request mask
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH
`define ISC_ADDR        8'h1A
`define ISC_RESET       8'h00
`define ISC_MODE_BIT    0
`define ISC_MASK_BIT    1
`define ISC_ACK_BIT     2
`define ISC_PEND_BIT    3
`define IST_ADDR        8'h1B
`define IEN_ADDR        8'h1C
`define IST_RESET       2'h0
`define IST_LATCH_BIT   0
`define IST_ACK_BIT     1
`endif

// file: core/ext_irq_pkg.sv
package ext_irq_pkg;
	typedef logic [7:0] reg8_t;
	typedef logic [1:0] evt_t;
endpackage : ext_irq_pkg

// file: core/external_irq_status_control.sv
`timescale 1ns/1ps
`include "ext_irq_map.svh"
module external_irq_status_control #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              irq_pin_n_i,
	input  wire logic              vector_fetch_i,
	input  wire logic              break_state_i,
	input  wire logic              break_clear_permit_i,
	output logic                   cpu_irq_req_o,
	output logic                   irq_o
);
	import ext_irq_pkg::*;

	// Refuse an address bus too narrow for the map
	if (ADDR_W < 8) begin : g_adr_check
		$error("ADDR_W must be at least 8");
	end

	// Reset images
	localparam reg8_t ISC_INIT = `ISC_RESET;
	localparam evt_t  IST_INIT = `IST_RESET;

	// Pin history for the edge detector
	logic               pin_q;
	logic               pin_d;

	// Interrupt latch
	logic               latch_q;
	logic               latch_d;

	// Sensitivity select
	logic               mode_q;
	logic               mode_d;

	// Request mask
	logic               mask_q;
	logic               mask_d;

	// Event status bits
	evt_t               ist_q;
	evt_t               ist_d;

	// Event enable bits
	evt_t               ien_q;
	evt_t               ien_d;

	// Bus answer
	logic               ack_q;
	logic               ack_d;
	logic [31:0]        dat_q;
	logic [31:0]        dat_d;

	// Bus request and decode
	logic               cyc_stb;
	logic               req;
	logic               wr_req;
	logic               wr_lane0;
	logic               upd;
	logic [7:0]         adr8;
	logic               hit_isc;
	logic               hit_ist;
	logic               hit_ien;
	logic               any_hit;
	logic               wr_isc;
	logic               wr_ist;
	logic               wr_ien;

	// Write data fields
	logic               wd_mode;
	logic               wd_mask;
	logic               wd_ack;
	logic               wd_evt0;
	logic               wd_evt1;
	evt_t               wd_evt;

	// Latch control
	logic               sw_ack;
	logic               brk_open;
	logic               ack_ok;
	logic               fetch_clr;
	logic               clr;
	logic               pin_low;
	logic               fall;
	logic               level;
	logic               set;
	logic               new_evt;
	evt_t               evt_set;
	evt_t               clr_evt;

	// Read side and outputs
	logic               pend;
	logic               rd_ack;
	reg8_t              isc_rd;
	logic [31:0]        rd_isc;
	logic [31:0]        rd_ist;
	logic [31:0]        rd_ien;
	logic [31:0]        rd_mux;
	evt_t               irq_hits;
	logic               req_out;

	// Bus request, taken once per transfer
	assign cyc_stb  = wb_cyc_i & wb_stb_i;
	assign req      = cyc_stb & ~ack_q;
	assign wr_req   = req & wb_we_i;
	assign wr_lane0 = wr_req & wb_sel_i[0];

	// Address decode on the low byte
	assign adr8     = wb_adr_i[7:0];
	assign hit_isc  = (adr8 == `ISC_ADDR);
	assign hit_ist  = (adr8 == `IST_ADDR);
	assign hit_ien  = (adr8 == `IEN_ADDR);
	assign any_hit  = hit_isc | hit_ist | hit_ien;

	// Register write strobes
	assign wr_isc   = wr_lane0 & hit_isc;
	assign wr_ist   = wr_lane0 & hit_ist;
	assign wr_ien   = wr_lane0 & hit_ien;

	// Control write fields
	assign wd_mode  = wb_dat_i[`ISC_MODE_BIT];
	assign wd_mask  = wb_dat_i[`ISC_MASK_BIT];
	assign wd_ack   = wb_dat_i[`ISC_ACK_BIT];

	// Status and enable write fields
	assign wd_evt0  = wb_dat_i[`IST_LATCH_BIT];
	assign wd_evt1  = wb_dat_i[`IST_ACK_BIT];
	assign wd_evt   = {wd_evt1, wd_evt0};

	// State moves only while the clock enable is high
	assign upd = ce_i;

	assign sw_ack = wr_isc & wd_ack;

	assign brk_open = ~break_state_i | break_clear_permit_i;

	assign ack_ok = sw_ack & brk_open;

	assign fetch_clr = vector_fetch_i;

	assign clr = ack_ok | fetch_clr;

	assign pin_low = ~irq_pin_n_i;

	assign fall = pin_q & pin_low;

	assign level = mode_q & pin_low;

	assign set = fall | level;

	// New latch event
	assign new_evt = set & ~latch_q;

	// Event set vector
	assign evt_set = {ack_ok, new_evt};

	// Event clear vector, write one to clear
	assign clr_evt = wr_ist ? wd_evt : 2'h0;

	assign pend = latch_q;

	assign rd_ack = 1'b0;

	// Control read image
	assign isc_rd = {4'h0, pend, rd_ack, mask_q, mode_q};

	assign req_out = latch_q & ~mask_q;

	// Enabled status events
	assign irq_hits = ist_q & ien_q;

	// Read words, upper bits zero
	assign rd_isc = {24'h0, isc_rd};
	assign rd_ist = {30'h0, ist_q};
	assign rd_ien = {30'h0, ien_q};

	// Read data selection, unmapped reads zero
	assign rd_mux = ~any_hit ? 32'h0 :
		hit_isc ? rd_isc :
		hit_ist ? rd_ist : rd_ien;

	// Pin sample for the edge detector
	always_comb begin
		pin_d = irq_pin_n_i;
	end

	always_comb begin
		latch_d = latch_q;
		if (clr) begin
			latch_d = 1'b0;
		end
		if (set) begin
			latch_d = 1'b1;
		end
	end

	always_comb begin
		mode_d = mode_q;
		if (wr_isc) begin
			mode_d = wd_mode;
		end
	end

	always_comb begin
		mask_d = mask_q;
		if (wr_isc) begin
			mask_d = wd_mask;
		end
	end

	// Event status, set wins over clear
	always_comb begin
		ist_d = ist_q & ~clr_evt;
		ist_d = ist_d | evt_set;
	end

	// Event enables written by software
	always_comb begin
		ien_d = ien_q;
		if (wr_ien) begin
			ien_d = wd_evt;
		end
	end

	// Answer one cycle after the request is taken
	always_comb begin
		ack_d = req;
	end

	// Read data registered for the answer cycle
	always_comb begin
		dat_d = rd_mux;
	end

	// Pin history, idle high after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 1'b1;
		end else if (upd) begin
			pin_q <= pin_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_q <= ISC_INIT[`ISC_PEND_BIT];
		end else if (upd) begin
			latch_q <= latch_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= ISC_INIT[`ISC_MODE_BIT];
		end else if (upd) begin
			mode_q <= mode_d;
		end
	end

	// Mask register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= ISC_INIT[`ISC_MASK_BIT];
		end else if (upd) begin
			mask_q <= mask_d;
		end
	end

	// Event status register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ist_q <= IST_INIT;
		end else if (upd) begin
			ist_q <= ist_d;
		end
	end

	// Event enable register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ien_q <= IST_INIT;
		end else if (upd) begin
			ien_q <= ien_d;
		end
	end

	// Bus acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else if (upd) begin
			ack_q <= ack_d;
		end
	end

	// Bus read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0;
		end else if (upd) begin
			dat_q <= dat_d;
		end
	end

	// Bus outputs
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Request to the CPU
	assign cpu_irq_req_o = req_out;

	// Level interrupt while any enabled event is set
	assign irq_o = |irq_hits;
endmodule : external_irq_status_control

// file: testbench/irq_props.sv
`timescale 1ns/1ps
module irq_props(input wire logic clk_i, rst_i, wb_stb_i, wb_we_i, wb_ack_o, irq_pin_n_i,
	break_state_i, break_clear_permit_i, cpu_irq_req_o,
	input wire logic [7:0] wb_adr_i, input wire logic [31:0] wb_dat_i, wb_dat_o);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence wr; wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h1A && wb_dat_i[2:1] == 2'h2;
	endsequence
	sequence rd; wb_ack_o && !wb_we_i && wb_adr_i == 8'h1A; endsequence
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
	a_ack_due: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
	a_ack_zero: assert property (wb_ack_o |-> !wb_dat_o[2]) else $error("ack");
	a_flag_tracks: assert property (rd ##0 !wb_dat_o[1] |->
		wb_dat_o[3] == $past(cpu_irq_req_o)) else $error("flag");
	a_mask_blocks: assert property (rd ##0 wb_dat_o[1] |->
		!$past(cpu_irq_req_o)) else $error("mask");
	a_rise_cause: assert property ($rose(cpu_irq_req_o) |-> wb_ack_o ||
		!$past(irq_pin_n_i) || !$past(irq_pin_n_i, 2)) else $error("rise");
	a_ack_clears: assert property (wr ##0 irq_pin_n_i && $past(irq_pin_n_i) &&
		(!break_state_i || break_clear_permit_i) |=> !cpu_irq_req_o) else $error("clr");
	a_break_hold: assert property (wr ##0 break_state_i && !break_clear_permit_i &&
		cpu_irq_req_o |=> cpu_irq_req_o) else $error("hold");
endmodule : irq_props
bind external_irq_status_control irq_props chk(.*);

// file: testbench/irq_cpu_model.sv
`timescale 1ns/1ps
module irq_cpu_model(
	input  wire logic clk_i,
	input  wire logic req_i,
	input  wire logic take_i,
	output logic      fetch_o = 1'h0
);
	always @(posedge clk_i) fetch_o <= req_i && take_i && !fetch_o;
endmodule : irq_cpu_model

// file: testbench/test_external_irq_status_control.sv
`timescale 1ns/1ps
module test_external_irq_status_control;
	logic        clk_i = 1'h0, rst_i = 1'h1, stb = 1'h0, we = 1'h0, pin = 1'h1, brk = 1'h0;
	logic        prm = 1'h0, tk = 1'h0, lat = 1'h0, mk = 1'h0, md = 1'h0, vf, ack, req, irq;
	logic        ce = 1'h1;
	logic [7:0]  adr = '0;
	logic [31:0] wd = '0, rd, q, lf = 32'hC4CC;
	int          failures, checks;
	always #5 clk_i = ~clk_i;
	external_irq_status_control dut(.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(stb), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .irq_pin_n_i(pin), .vector_fetch_i(vf), .break_state_i(brk),
		.break_clear_permit_i(prm), .cpu_irq_req_o(req), .irq_o(irq));
	irq_cpu_model cpu(.clk_i, .req_i(req), .take_i(tk), .fetch_o(vf));
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nx
	task automatic chk(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk_i) {adr, wd, we, stb} <= {a, d, w, 1'h1};
		do @(posedge clk_i); while (ack !== 1'h1);
		q = rd;
		stb <= 1'h0;
		if (w && a == 8'h1A)
			{lat, mk, md} = {lat && !(d[2] && (!brk || prm)) || d[0] && !pin, d[1:0]};
		@(posedge clk_i);
		if (!w)
			chk(q, a == 8'h1A ? {lat, 1'h0, mk, md} : 0);
		chk(req, lat && !mk);
	endtask : op
	task automatic pn(input logic v);
		@(posedge clk_i) pin <= v;
		lat = lat || !v;
		repeat (3) @(posedge clk_i);
	endtask : pn
	initial begin
		#100us;
		failures++;
		print_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		op(8'h1A, 0, 0);
		op(8'h1C, 1, 1);
		pn(1'h0);
		chk(irq, 1);
		op(8'h1C, 0, 1);
		chk(irq, 0);
		op(8'h1B, 3, 1);
		op(8'h1C, 1, 1);
		chk(irq, 0);
		op(8'h1A, 2, 1);
		op(8'h1A, 0, 0);
		{brk, prm} <= 2'h2;
		op(8'h1A, 4, 1);
		prm <= 1'h1;
		op(8'h1A, 4, 1);
		brk <= 1'h0;
		op(8'h1A, 0, 0);
		op(8'h1A, 1, 1);
		op(8'h1A, 5, 1);
		pn(1'h1);
		op(8'h1A, 5, 1);
		op(8'h1A, 0, 1);
		pn(1'h0);
		tk <= 1'h1;
		repeat (2) @(posedge clk_i);
		lat = 1'h0;
		op(8'h1A, 0, 0);
		ce <= 1'h0;
		pn(1'h1);
		pn(1'h0);
		ce <= 1'h1;
		lat = 1'h0;
		op(8'h1A, 0, 0);
		repeat (4) begin
			lf = nx(lf);
			op({3'h2, lf[4:0]}, lf, 1);
			op({3'h2, lf[4:0]}, 0, 0);
		end
		print_verdict();
	end
endmodule : test_external_irq_status_control
